// file: logic/ttpm_pkg.sv
// Package for the thermistor trip and pulse monitor block
package ttpm_pkg;
    // Thermistor protection select codes
    localparam logic [1:0] TH_OFF = 2'h0;
    localparam logic [1:0] TH_PTC = 2'h1;
    localparam logic [1:0] TH_NTC = 2'h2;
    // Setting ranges
    localparam logic [13:0] TRIP_LEVEL_MAX   = 14'h270F;    // 9999 ohms
    localparam logic [13:0] TH_GAIN_MAX      = 14'h2710;    // 1000.0 in tenths
    localparam logic [13:0] TH_GAIN_UNITY    = 14'h03E8;    // 100.0 in tenths
    localparam logic [13:0] TH_OPEN_OHMS     = 14'h3FFF;    // Raw reading of an open input
    localparam logic [7:0]  PM_GAIN_MIN      = 8'h32;       // 50 percent
    localparam logic [7:0]  PM_GAIN_MAX      = 8'hC8;       // 200 percent
    localparam logic [7:0]  PM_GAIN_RESET    = 8'h64;       // 100 percent
    localparam logic [7:0]  CM_REF_MIN       = 8'h14;       // 0.2 x rated, percent
    localparam logic [7:0]  CM_REF_MAX       = 8'h96;       // 1.5 x rated, percent
    // Pulse monitor source codes
    localparam logic [3:0] SRC_FREQ   = 4'h0;
    localparam logic [3:0] SRC_CURR   = 4'h1;
    localparam logic [3:0] SRC_TORQ   = 4'h2;
    localparam logic [3:0] SRC_DFREQ  = 4'h3;
    localparam logic [3:0] SRC_VOLT   = 4'h4;
    localparam logic [3:0] SRC_POWER  = 4'h5;
    localparam logic [3:0] SRC_THERM  = 4'h6;
    localparam logic [3:0] SRC_RAMP   = 4'h7;
    localparam logic [3:0] SRC_DCURR  = 4'h8;
    localparam logic [3:0] SRC_MTEMP  = 4'h9;
    localparam logic [3:0] SRC_HTEMP  = 4'hA;
    localparam logic [3:0] SRC_ANALOG = 4'hC;
    // Full scale values, in tenths of a percent or tenths of a degree
    localparam logic [15:0] FS_200PCT = 16'h07D0;
    localparam logic [15:0] FS_133PCT = 16'h0533;
    localparam logic [15:0] FS_100PCT = 16'h03E8;
    localparam logic [15:0] FS_200DEG = 16'h07D0;
    // Timing
    localparam int CLK_HZ       = 25000000;
    localparam int MATCH_HZ     = 1440;
    localparam int MATCH_HALF   = CLK_HZ / (2 * MATCH_HZ);
    localparam int PWM_BITS     = 10;
    // Register map (byte addresses)
    localparam logic [7:0] A_TH_SEL   = 8'h00;
    localparam logic [7:0] A_TRIP_LVL = 8'h04;
    localparam logic [7:0] A_TH_GAIN  = 8'h08;
    localparam logic [7:0] A_PM_SRC   = 8'h0C;
    localparam logic [7:0] A_CM_REF   = 8'h10;
    localparam logic [7:0] A_PM_GAIN  = 8'h14;
    localparam logic [7:0] A_STATUS   = 8'h18;
    localparam logic [7:0] A_IRQ_STS  = 8'h1C;
    localparam logic [7:0] A_IRQ_EN   = 8'h20;
    localparam logic [7:0] A_IRQ_CLR  = 8'h24;
    localparam logic [7:0] A_TRIP_RST = 8'h28;
    // Interrupt bits
    localparam int IRQ_TRIP  = 0;
    localparam int IRQ_MATCH = 1;
    // Register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ttpm_bus_t;
    // Drive quantities sampled by the monitor
    typedef struct packed {
        logic [15:0] out_freq;      // Hz x10
        logic [15:0] ramp_freq;     // Hz x10
        logic [15:0] max_freq;      // Hz x10
        logic [15:0] current;       // Percent of rating x10
        logic [15:0] torque;        // Percent x10
        logic [15:0] voltage;       // Percent x10
        logic [15:0] power;         // Percent x10
        logic [15:0] thermal;       // Percent x10
        logic signed [15:0] motor_temp;  // Degrees x10
        logic signed [15:0] sink_temp;   // Degrees x10
        logic [15:0] analog;        // Percent x10
    } ttpm_drive_t;
endpackage : ttpm_pkg

// file: logic/ttpm_top.sv
// Thermistor trip and pulse monitor logic
// Functional notes
// - Protect select: 00 off, 01 positive coefficient, 02 negative coefficient.
// - Trip when trimmed resistance reaches trip level, settable 0 to 9999.
// - Gain trim on thermistor reading, settable 0.0 to 1000.
// - Positive coefficient selected with no thermistor connected trips the drive.
// - Sources 00 and 07: output or ramp frequency, maximum frequency full scale.
// - Sources 01, 02, 05: current, torque, power, 200 percent full scale.
// - Source 04: voltage, 133 percent full scale.
// - Sources 06 and 12: thermal overload or analog value, 100 percent scale.
// - Sources 09 and 10: temperatures over 0 to 200 degrees, negatives clamped.
// - Source 03: pulse train whose frequency follows output frequency.
// - Current match mode drives 1440 Hz when current matches reference.
// - Current reference accepted from 0.2 to 1.5 times rated current.
// - Torque source only given under sensorless vector control.
// - Meter output scaled by gain settable 50 to 200 percent.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ttpm_top
    import ttpm_pkg::*;
#(
    parameter int MATCH_TOL = 5     // Current match window, tenths of percent
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 clk_en_i,
    input  wire ttpm_pkg::ttpm_bus_t  bus_i,
    output logic [31:0]               rdata_o,
    input  wire logic [13:0]          th_ohms_i,
    input  wire logic                 th_present_i,
    input  wire logic                 svc_mode_i,
    input  wire ttpm_pkg::ttpm_drive_t drive_i,
    output logic                      trip_o,
    output logic                      pulse_monitor_pin_o,
    output logic                      irq_o
);
    import ttpm_pkg::*;

    if (MATCH_TOL < 0 || MATCH_TOL > 100) begin : g_bad_tol
        $error("MATCH_TOL out of range");
    end

    // Settings
    logic [1:0]  thermistor_protect_select;
    logic [13:0] thermal_trip_level;
    logic [13:0] thermistor_input_gain;
    logic [3:0]  pulse_monitor_source_select;
    logic [7:0]  current_match_reference;
    logic [7:0]  pulse_monitor_gain;
    logic        trip;
    logic [1:0]  irq_sts;
    logic [1:0]  irq_en;
    logic        match_q;
    logic [31:0] rdata;

    // Address decode
    wire wr_sel   = bus_i.wr && clk_en_i;
    wire w_sel    = wr_sel && bus_i.addr == A_TH_SEL;
    wire w_lvl    = wr_sel && bus_i.addr == A_TRIP_LVL;
    wire w_gain   = wr_sel && bus_i.addr == A_TH_GAIN;
    wire w_src    = wr_sel && bus_i.addr == A_PM_SRC;
    wire w_ref    = wr_sel && bus_i.addr == A_CM_REF;
    wire w_pgain  = wr_sel && bus_i.addr == A_PM_GAIN;
    wire w_ien    = wr_sel && bus_i.addr == A_IRQ_EN;
    wire w_iclr   = wr_sel && bus_i.addr == A_IRQ_CLR;
    wire w_trst   = wr_sel && bus_i.addr == A_TRIP_RST && bus_i.wdata[0];

    // Range limited write values; out of range writes are clamped, a protect select write of 3 is ignored
    wire [13:0] wd14      = bus_i.wdata[13:0];
    wire [7:0]  wd8       = bus_i.wdata[7:0];
    wire [13:0] lvl_wr    = (wd14 > TRIP_LEVEL_MAX) ? TRIP_LEVEL_MAX : wd14;
    wire [13:0] gain_wr   = (wd14 > TH_GAIN_MAX) ? TH_GAIN_MAX : wd14;
    wire [7:0]  ref_wr    = (wd8 < CM_REF_MIN) ? CM_REF_MIN :
                            (wd8 > CM_REF_MAX) ? CM_REF_MAX : wd8;
    wire [7:0]  pgain_wr  = (wd8 < PM_GAIN_MIN) ? PM_GAIN_MIN :
                            (wd8 > PM_GAIN_MAX) ? PM_GAIN_MAX : wd8;
    wire        sel_ok    = bus_i.wdata[1:0] != 2'h3;

    // Settings registers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            thermistor_protect_select   <= TH_OFF;
            thermal_trip_level          <= TRIP_LEVEL_MAX;
            thermistor_input_gain       <= TH_GAIN_UNITY;
            pulse_monitor_source_select <= SRC_FREQ;
            current_match_reference     <= CM_REF_MIN;
            pulse_monitor_gain          <= PM_GAIN_RESET;
        end else begin
            if (w_sel && sel_ok) thermistor_protect_select <= bus_i.wdata[1:0];
            if (w_lvl)   thermal_trip_level          <= lvl_wr;
            if (w_gain)  thermistor_input_gain       <= gain_wr;
            if (w_src)   pulse_monitor_source_select <= bus_i.wdata[3:0];
            if (w_ref)   current_match_reference     <= ref_wr;
            if (w_pgain) pulse_monitor_gain          <= pgain_wr;
        end
    end

    // Thermistor trim: resistance x gain / 100.0, saturated to 14 bits
    wire [27:0] th_prod   = th_ohms_i * thermistor_input_gain;
    wire [27:0] th_div    = th_prod / 28'(TH_GAIN_UNITY);
    wire [13:0] th_trim   = (th_div > 28'(TH_OPEN_OHMS)) ? TH_OPEN_OHMS : th_div[13:0];
    // Positive coefficient trips as resistance rises, negative as it falls
    wire ptc_hit  = thermistor_protect_select == TH_PTC &&
                    (th_trim >= thermal_trip_level || !th_present_i);
    wire ntc_hit  = thermistor_protect_select == TH_NTC && th_present_i &&
                    th_trim <= thermal_trip_level;
    wire trip_set = ptc_hit || ntc_hit;

    // Trip latch; a fresh trip wins over a reset in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            trip <= 1'b0;
        end else if (clk_en_i) begin
            trip <= trip_set || (trip && !w_trst);
        end
    end

    // Current match detect within a small window
    wire [15:0] ref_pct   = {8'h00, current_match_reference} * 16'h000A;
    wire [15:0] cur_diff  = (drive_i.current > ref_pct) ? drive_i.current - ref_pct
                                                          : ref_pct - drive_i.current;
    wire        cur_match = cur_diff <= 16'(MATCH_TOL);

    // Source selection and full scale
    logic [15:0] src_val;
    logic [15:0] src_fs;
    wire [15:0] mtemp = drive_i.motor_temp[15] ? 16'h0000 : drive_i.motor_temp;
    wire [15:0] htemp = drive_i.sink_temp[15] ? 16'h0000 : drive_i.sink_temp;
    always_comb begin
        src_val = 16'h0000;
        src_fs  = FS_100PCT;
        case (pulse_monitor_source_select)
            SRC_FREQ:   begin src_val = drive_i.out_freq;  src_fs = drive_i.max_freq; end
            SRC_RAMP:   begin src_val = drive_i.ramp_freq; src_fs = drive_i.max_freq; end
            SRC_CURR:   begin src_val = drive_i.current;   src_fs = FS_200PCT; end
            SRC_TORQ:   begin src_val = svc_mode_i ? drive_i.torque : 16'h0000;
                              src_fs = FS_200PCT; end
            SRC_POWER:  begin src_val = drive_i.power;     src_fs = FS_200PCT; end
            SRC_VOLT:   begin src_val = drive_i.voltage;   src_fs = FS_133PCT; end
            SRC_THERM:  begin src_val = drive_i.thermal;   src_fs = FS_100PCT; end
            SRC_ANALOG: begin src_val = drive_i.analog;    src_fs = FS_100PCT; end
            SRC_MTEMP:  begin src_val = mtemp;             src_fs = FS_200DEG; end
            SRC_HTEMP:  begin src_val = htemp;             src_fs = FS_200DEG; end
            default:    begin src_val = 16'h0000;          src_fs = FS_100PCT; end
        endcase
    end

    // Linear duty: value x gain / full scale, clamped at full duty
    // 48 bits so a large quantity still clamps instead of wrapping
    wire [47:0] scaled   = 48'(src_val) * 48'(pulse_monitor_gain) * 48'h000000000400;
    wire [47:0] fs_x100  = 48'(src_fs) * 48'h000000000064;
    wire [47:0] duty_raw = (src_fs == 16'h0000) ? 48'h000000000000 : scaled / fs_x100;
    wire [PWM_BITS-1:0] duty = (duty_raw > 48'h0000000003FF) ? 10'h3FF
                                                            : duty_raw[PWM_BITS-1:0];

    // Meter mode PWM carrier
    logic [PWM_BITS-1:0] pwm_cnt;
    logic [PWM_BITS-1:0] duty_q;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pwm_cnt <= '0;
            duty_q  <= '0;
        end else if (clk_en_i) begin
            pwm_cnt <= pwm_cnt + 1'b1;
            if (pwm_cnt == '1) duty_q <= duty;
        end
    end
    wire pwm_out = pwm_cnt < duty_q;

    // Frequency pulse train: phase accumulator, output rate = out_freq / 10 Hz
    // Step near 2^38 / (25 MHz x 10); rounding leaves the rate about 0.05 percent high
    localparam logic [31:0] HZ10_STEP = 32'h0000044C;
    logic [37:0] phase;
    wire [37:0] dfreq_step = {22'h000000, drive_i.out_freq} * 38'(HZ10_STEP);
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            phase <= '0;
        end else if (clk_en_i) begin
            phase <= phase + dfreq_step;
        end
    end
    wire dfreq_out = phase[37];

    // 1440 Hz square wave for current match
    localparam int HALF_W = $clog2(MATCH_HALF + 1);
    logic [HALF_W-1:0] half_cnt;
    logic              match_wave;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            half_cnt   <= '0;
            match_wave <= 1'b0;
        end else if (clk_en_i) begin
            if (half_cnt == HALF_W'(MATCH_HALF - 1)) begin
                half_cnt   <= '0;
                match_wave <= ~match_wave;
            end else begin
                half_cnt <= half_cnt + 1'b1;
            end
        end
    end

    // Output pin register
    logic next_pin;
    always_comb begin
        case (pulse_monitor_source_select)
            SRC_DFREQ: next_pin = dfreq_out;
            SRC_DCURR: next_pin = cur_match & match_wave;
            default:   next_pin = pwm_out;
        endcase
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pulse_monitor_pin_o <= 1'b0;
            match_q             <= 1'b0;
        end else if (clk_en_i) begin
            pulse_monitor_pin_o <= next_pin;
            match_q             <= cur_match;
        end
    end

    // Interrupt status: set wins over clear
    wire [1:0] irq_evt = {cur_match & ~match_q, trip_set & ~trip};
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_sts <= 2'h0;
            irq_en  <= 2'h0;
        end else if (clk_en_i) begin
            irq_sts <= irq_evt | (irq_sts & ~({2{w_iclr}} & bus_i.wdata[1:0]));
            if (w_ien) irq_en <= bus_i.wdata[1:0];
        end
    end

    // Read mux, data valid one cycle after the strobe
    always_comb begin
        case (bus_i.addr)
            A_TH_SEL:   rdata = {30'h0, thermistor_protect_select};
            A_TRIP_LVL: rdata = {18'h0, thermal_trip_level};
            A_TH_GAIN:  rdata = {18'h0, thermistor_input_gain};
            A_PM_SRC:   rdata = {28'h0, pulse_monitor_source_select};
            A_CM_REF:   rdata = {24'h0, current_match_reference};
            A_PM_GAIN:  rdata = {24'h0, pulse_monitor_gain};
            A_STATUS:   rdata = {16'h0, th_trim, match_q, trip};
            A_IRQ_STS:  rdata = {30'h0, irq_sts};
            A_IRQ_EN:   rdata = {30'h0, irq_en};
            default:    rdata = 32'h00000000;
        endcase
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_o <= 32'h00000000;
        end else if (clk_en_i) begin
            rdata_o <= bus_i.rd ? rdata : 32'h00000000;
        end
    end

    assign trip_o = trip;
    assign irq_o  = |(irq_sts & irq_en);

    // Assertions
    property p_trip_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        trip && clk_en_i && !w_trst |=> trip;
    endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("trip dropped");

    property p_trip_set;
        @(posedge ref_clk_i) disable iff (rst_i)
        trip_set && clk_en_i |=> trip_o;
    endproperty
    a_trip_set: assert property (p_trip_set) else $error("trip not raised");

    property p_open_ptc;
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && thermistor_protect_select == TH_PTC && !th_present_i |=> trip;
    endproperty
    a_open_ptc: assert property (p_open_ptc) else $error("open ptc no trip");

    property p_off_notrip;
        @(posedge ref_clk_i) disable iff (rst_i)
        thermistor_protect_select == TH_OFF |-> !trip_set;
    endproperty
    a_off_notrip: assert property (p_off_notrip) else $error("trip while off");

    property p_gain_range;
        @(posedge ref_clk_i) disable iff (rst_i)
        pulse_monitor_gain >= PM_GAIN_MIN && pulse_monitor_gain <= PM_GAIN_MAX;
    endproperty
    a_gain_range: assert property (p_gain_range) else $error("gain range");

    property p_ref_range;
        @(posedge ref_clk_i) disable iff (rst_i)
        current_match_reference >= CM_REF_MIN && current_match_reference <= CM_REF_MAX;
    endproperty
    a_ref_range: assert property (p_ref_range) else $error("reference range");

    property p_nomatch_low;
        @(posedge ref_clk_i) disable iff (rst_i)
        clk_en_i && pulse_monitor_source_select == SRC_DCURR && !cur_match
            |=> !pulse_monitor_pin_o;
    endproperty
    a_nomatch_low: assert property (p_nomatch_low) else $error("pin high no match");

    property p_torq_svc;
        @(posedge ref_clk_i) disable iff (rst_i)
        pulse_monitor_source_select == SRC_TORQ && !svc_mode_i |-> src_val == 16'h0000;
    endproperty
    a_torq_svc: assert property (p_torq_svc) else $error("torque without svc");

    property p_temp_clamp;
        @(posedge ref_clk_i) disable iff (rst_i)
        (pulse_monitor_source_select == SRC_MTEMP && drive_i.motor_temp[15]) ||
        (pulse_monitor_source_select == SRC_HTEMP && drive_i.sink_temp[15])
            |-> duty == '0;
    endproperty
    a_temp_clamp: assert property (p_temp_clamp) else $error("negative temp");

    c_trip:   cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(trip));
    c_match:  cover property (@(posedge ref_clk_i) disable iff (rst_i)
                              cur_match && pulse_monitor_source_select == SRC_DCURR);
    c_full:   cover property (@(posedge ref_clk_i) disable iff (rst_i) duty == 10'h3FF);
endmodule : ttpm_top
`default_nettype wire

// file: dv/ttpm_partner.sv
// Far side model: thermistor on the input pins, meter or counter on the pulse pin
`timescale 1ns/10ps
`default_nettype none
module ttpm_partner (
    input  wire logic        ref_clk_i,
    input  wire logic        clr_i,
    input  wire logic [13:0] set_ohms_i,
    input  wire logic        fitted_i,
    input  wire logic        pin_i,
    output logic [13:0]      th_ohms_o,
    output logic             th_present_o,
    output logic [15:0]      high_cnt_o,
    output logic [15:0]      edge_cnt_o
);
    logic pin_d;
    // Open input wanders; a stale reading would hide a missing check
    always_ff @(posedge ref_clk_i) begin
        th_present_o <= fitted_i;
        th_ohms_o    <= fitted_i ? set_ohms_i : th_ohms_o ^ 14'h2AAA;
        pin_d        <= pin_i;
        high_cnt_o   <= clr_i ? 16'h0000 : high_cnt_o + {15'h0000, pin_i};
        edge_cnt_o   <= clr_i ? 16'h0000 : edge_cnt_o + {15'h0000, pin_i & ~pin_d};
    end
endmodule : ttpm_partner
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the thermistor trip and pulse monitor
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import ttpm_pkg::*;
    logic        ref_clk, rst, clr, fit, svc, trip, pin, irq, en;
    logic [31:0] rdata, d;
    logic [13:0] set_ohms, ohms, lvl;
    logic [15:0] hi, ed, e1;
    logic        pres;
    logic [7:0]  g, r;
    ttpm_bus_t   bus;
    ttpm_drive_t drv;
    int          seed, mismatches, num_checks;
    logic [7:0]  ra [6] = '{A_TH_SEL, A_TRIP_LVL, A_TH_GAIN, A_PM_SRC, A_CM_REF, A_PM_GAIN};
    logic [31:0] rv [6] = '{0, 9999, 1000, 0, 20, 100};
    logic [7:0]  ca [6] = '{A_PM_GAIN, A_PM_GAIN, A_CM_REF, A_CM_REF, A_TH_SEL, 8'h3C};
    logic [31:0] cw [6] = '{250, 10, 200, 5, 3, 8'h5A};
    logic [31:0] ce [6] = '{200, 50, 150, 20, 0, 0};

    ttpm_top DUT (.ref_clk_i(ref_clk), .rst_i(rst), .clk_en_i(en), .bus_i(bus),
        .rdata_o(rdata), .th_ohms_i(ohms), .th_present_i(pres), .svc_mode_i(svc),
        .drive_i(drv), .trip_o(trip), .pulse_monitor_pin_o(pin), .irq_o(irq));
    ttpm_partner far (.ref_clk_i(ref_clk), .clr_i(clr), .set_ohms_i(set_ohms),
        .fitted_i(fit), .pin_i(pin), .th_ohms_o(ohms), .th_present_o(pres),
        .high_cnt_o(hi), .edge_cnt_o(ed));

    // 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input int tol);
        num_checks++;
        if (!(seen === exp) && !(tol > 0 && (^seen !== 1'bx) && seen + tol >= exp
            && seen <= exp + tol)) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge ref_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
        @(posedge ref_clk);
        bus <= '0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge ref_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge ref_clk);
        bus <= '0;
        @(negedge ref_clk);
        q = rdata;
    endtask : rd

    task automatic measure(input int n);
        @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : measure

    task automatic trip_case(input logic [1:0] s, input logic [13:0] gn, input logic [13:0] lv,
                             input logic [13:0] oh, input logic f, input logic e);
        wr(A_TH_SEL, 0);
        wr(A_TRIP_RST, 1);
        set_ohms <= oh;
        fit      <= f;
        wr(A_TRIP_LVL, {18'h0, lv});
        wr(A_TH_GAIN, {18'h0, gn});
        wr(A_TH_SEL, {30'h0, s});
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        check({31'h0, trip}, {31'h0, e}, 0);
    endtask : trip_case

    // Expected PWM high count per 1024 cycles, clamped at the top
    function automatic logic [31:0] duty(input logic [15:0] v, input logic [15:0] fs,
                                         input logic [7:0] gn);
        logic [63:0] x;
        x = (64'(v) * 64'(gn) * 64'd1024) / (64'(fs) * 64'd100);
        return (x > 64'd1023) ? 32'd1023 : x[31:0];
    endfunction : duty

    task automatic pm_case(input logic [3:0] s, input logic [31:0] e);
        wr(A_PM_GAIN, {24'h0, g});
        wr(A_PM_SRC, {28'h0, s});
        repeat (1100) @(posedge ref_clk);
        measure(1024);
        check({16'h0, hi}, e, 2);
    endtask : pm_case

    // Watchdog
    initial begin
        #(40 * 110000);
        mismatches++;
        report_and_stop();
    end

    initial begin
        seed = 50;
        {rst, clr, fit, svc, set_ohms, bus, drv} = '0;
        rst = 1'b1;
        fit = 1'b1;
        en  = 1'b1;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], d);
            check(d, rv[i], 0);
        end
        for (int i = 0; i < 6; i++) begin
            wr(ca[i], cw[i]);
            rd(ca[i], d);
            check(d, ce[i], 0);
        end
        // Writes are ignored while the clock enable is low
        @(posedge ref_clk);
        en <= 1'b0;
        wr(A_PM_GAIN, 32'h00000096);
        en <= 1'b1;
        rd(A_PM_GAIN, d);
        check(d, {24'h0, PM_GAIN_MIN}, 0);
        lvl = 14'($unsigned($random(seed)) % 9000) + 14'd500;
        trip_case(TH_PTC, 1000, lvl, lvl - 1, 1, 0);
        trip_case(TH_PTC, 1000, 9999, 9999, 1, 1);
        trip_case(TH_NTC, 1000, lvl, lvl + 1, 1, 0);
        trip_case(TH_NTC, 1000, lvl, lvl, 1, 1);
        trip_case(TH_OFF, 1000, lvl, lvl, 1, 0);
        trip_case(TH_PTC, 1000, lvl, 0, 0, 1);
        trip_case(TH_NTC, 1000, lvl, 0, 0, 0);
        trip_case(TH_PTC, 2000, lvl, (lvl + 1) / 2, 1, 1);
        trip_case(TH_PTC, 2000, lvl, lvl / 2 - 1, 1, 0);
        trip_case(TH_PTC, 0, lvl, 9999, 1, 0);
        trip_case(TH_PTC, 10000, lvl, lvl / 10 + 1, 1, 1);
        // Interrupt raise, mask and clear around a latched trip
        wr(A_TH_SEL, 0);
        wr(A_TRIP_RST, 1);
        wr(A_IRQ_CLR, 3);
        wr(A_IRQ_EN, 1);
        trip_case(TH_PTC, 1000, lvl, lvl, 1, 1);
        check({31'h0, irq}, 1, 0);
        wr(A_TRIP_RST, 1);
        repeat (2) @(posedge ref_clk);
        check({31'h0, trip}, 1, 0);
        set_ohms <= 0;
        repeat (4) @(posedge ref_clk);
        check({31'h0, trip}, 1, 0);
        rd(A_IRQ_STS, d);
        check({31'h0, d[IRQ_TRIP]}, 1, 0);
        wr(A_IRQ_EN, 0);
        @(negedge ref_clk);
        check({31'h0, irq}, 0, 0);
        wr(A_IRQ_CLR, 3);
        rd(A_IRQ_STS, d);
        check(d, 0, 0);
        wr(A_TRIP_RST, 1);
        repeat (2) @(posedge ref_clk);
        check({31'h0, trip}, 0, 0);
        // Meter sources with random values and gains; voltage, heatsink and overrange current cases fixed
        drv.max_freq  <= 16'd6000;
        drv.out_freq  <= 16'($unsigned($random(seed)) % 6000);
        drv.ramp_freq <= 16'($unsigned($random(seed)) % 6000);
        drv.current   <= 16'($unsigned($random(seed)) % 2000);
        drv.torque    <= 16'($unsigned($random(seed)) % 2000);
        drv.voltage   <= 16'd1000;
        drv.power     <= 16'($unsigned($random(seed)) % 2000);
        drv.thermal   <= 16'($unsigned($random(seed)) % 1000);
        drv.analog    <= 16'($unsigned($random(seed)) % 1000);
        drv.motor_temp <= 16'($unsigned($random(seed)) % 2000);
        drv.sink_temp <= -16'sd150;
        g = 8'($unsigned($random(seed)) % 151) + 8'd50;
        @(posedge ref_clk);
        pm_case(SRC_FREQ, duty(drv.out_freq, drv.max_freq, g));
        pm_case(SRC_RAMP, duty(drv.ramp_freq, drv.max_freq, g));
        pm_case(SRC_CURR, duty(drv.current, FS_200PCT, g));
        pm_case(SRC_TORQ, 0);
        svc <= 1'b1;
        pm_case(SRC_TORQ, duty(drv.torque, FS_200PCT, g));
        pm_case(SRC_POWER, duty(drv.power, FS_200PCT, g));
        pm_case(SRC_THERM, duty(drv.thermal, FS_100PCT, g));
        pm_case(SRC_ANALOG, duty(drv.analog, FS_100PCT, g));
        pm_case(SRC_MTEMP, duty(drv.motor_temp, FS_200DEG, g));
        pm_case(SRC_HTEMP, 0);
        g = 8'd100;
        pm_case(SRC_VOLT, 768);
        g = PM_GAIN_MAX;
        drv.current <= 16'd2600;
        pm_case(SRC_CURR, 1023);
        // Current match indication at the 1440 Hz rate
        r = 8'($unsigned($random(seed)) % 131) + 8'd20;
        wr(A_IRQ_CLR, 3);
        wr(A_CM_REF, {24'h0, r});
        drv.current <= 16'(r) * 16'd10;
        wr(A_PM_SRC, {28'h0, SRC_DCURR});
        repeat (100) @(posedge ref_clk);
        measure(3 * MATCH_HALF);
        check({16'h0, ed}, 2, 1);
        rd(A_IRQ_STS, d);
        check({31'h0, d[IRQ_MATCH]}, 1, 0);
        rd(A_STATUS, d);
        check(d, 32'h00000002, 0);
        drv.current <= 16'(r) * 16'd10 + 16'd50;
        repeat (10) @(posedge ref_clk);
        measure(MATCH_HALF + 400);
        check({16'h0, ed}, 0, 0);
        // Pulse train follows output frequency
        wr(A_PM_SRC, {28'h0, SRC_DFREQ});
        drv.out_freq <= 16'd16000;
        measure(8192);
        e1 = ed;
        drv.out_freq <= 16'd64000;
        measure(8192);
        check({31'h0, ed > e1}, 1, 0);
        drv.out_freq <= 16'd0;
        repeat (10) @(posedge ref_clk);
        measure(4096);
        check({16'h0, ed}, 0, 0);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
